//--- rtl/asmc_cfg.svh
// Purpose: timing counts and widths for the async static memory host
// Assumes: 50 MHz clock, 20 ns period
// Notes:   each time used for a cycle count rounds up to whole clock cycles, longest times too
`ifndef ASMC_CFG_SVH
`define ASMC_CFG_SVH

`define ASMC_CLK_PERIOD_NS        20
`define ASMC_ADDR_W               19
`define ASMC_DATA_W               8
`define ASMC_WORDS                524288
// times in ns
`define ASMC_ADDRESS_ACCESS_NS    100
`define ASMC_ENABLE_ACCESS_NS     100
`define ASMC_OE_ACCESS_NS         50
`define ASMC_MIN_CYCLE_NS         100
`define ASMC_STROBE_TO_HIGH_Z_NS  30
`define ASMC_STROBE_PULSE_NS      60
`define ASMC_SELECT_TO_END_NS     80
`define ASMC_OE_HIGH_Z_NS         30
`define ASMC_DATA_SETUP_NS        40
`define ASMC_WRITE_DISABLE_NS     5
// cycle counts derived from the times
`define ASMC_CYC_UP(t) (((t) + `ASMC_CLK_PERIOD_NS - 1) / `ASMC_CLK_PERIOD_NS)
// read wait: access time, one margin cycle, two sync stages
`define ASMC_READ_CYC   (`ASMC_CYC_UP(`ASMC_ADDRESS_ACCESS_NS) + 3)
`define ASMC_HIZ_CYC    `ASMC_CYC_UP(`ASMC_STROBE_TO_HIGH_Z_NS)
`define ASMC_WPULSE_CYC `ASMC_CYC_UP(`ASMC_SELECT_TO_END_NS)
`define ASMC_OEOFF_CYC  `ASMC_CYC_UP(`ASMC_OE_HIGH_Z_NS)
`define ASMC_RECOV_CYC  `ASMC_CYC_UP(`ASMC_MIN_CYCLE_NS)
`define ASMC_CNT_W      4

`endif

//--- rtl/asmc_pkg.sv
// Purpose: types for the async static memory host
// Assumes: constants come from asmc_cfg.svh
// Notes:   none
package asmc_pkg;
    typedef enum logic [2:0] {
        ASMC_IDLE,
        ASMC_RD_ACCESS,
        ASMC_RD_OFF,
        ASMC_WR_HIZ,
        ASMC_WR_PULSE,
        ASMC_RECOVER
    } asmc_state_t;
endpackage : asmc_pkg

//--- rtl/asmc_sync.sv
// Purpose: two-flop synchroniser for the data pins
// Assumes: one clock
// Notes:   first stage read only by second
`timescale 1ns/100ps
`include "asmc_cfg.svh"
module asmc_sync (
    input  wire logic                    clock,
    input  wire logic                    rstn,
    input  wire logic [`ASMC_DATA_W-1:0] din,
    output logic      [`ASMC_DATA_W-1:0] dout
);
    logic [`ASMC_DATA_W-1:0] meta_reg;
    logic [`ASMC_DATA_W-1:0] dout_reg;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            meta_reg <= '0;
            dout_reg <= '0;
        end else begin
            meta_reg <= din;
            dout_reg <= meta_reg;
        end
    end
    assign dout = dout_reg;
endmodule : asmc_sync

//--- rtl/asmc_host.sv
// Purpose: host that reads and writes an async 512K x 8 static memory
// Assumes: 50 MHz clock; memory pins are asynchronous to it
// Notes:   one request at a time, accepted on req_valid with req_ready
// Notes on behaviour
// (R1) 19 address lines pick one byte
// (R2) memory floats data when deselected or off
// (R3) write: select low, strobe low
// (R4) read: select, output low, strobe high
// (R5) output high keeps read internal, floated
// (R6) select high between accesses saves power
// (R7) access counted from last enabling event
// (R8) data valid 100ns after stable address
// (R9) address change starts new access
// (R10) address changes spaced one cycle time
// (R11) address steady through enable-led read
// (R12) output-enable read waits all access times
// (R13) strobe width from later falling control
// (R14) wait strobe-to-float before driving data
// (R15) write may end by select rising
// (R16) memory stores data at ending edge
`timescale 1ns/100ps
`include "asmc_cfg.svh"
module asmc_host (
    input  wire logic                    clock,
    input  wire logic                    rstn,
    input  wire logic                    req_valid,
    input  wire logic                    req_write,
    input  wire logic [`ASMC_ADDR_W-1:0] req_addr,
    input  wire logic [`ASMC_DATA_W-1:0] req_wdata,
    output logic                         req_ready,
    output logic                         rsp_valid,
    output logic      [`ASMC_DATA_W-1:0] rsp_rdata,
    output logic      [`ASMC_ADDR_W-1:0] mem_addr,
    output logic                         chip_on_n,
    output logic                         output_on_n,
    output logic                         stor_strob_n,
    input  wire logic [`ASMC_DATA_W-1:0] data_in,
    output logic      [`ASMC_DATA_W-1:0] data_out,
    output logic                         data_oe_n
);
    // each wait state counts down to one, then moves on
    localparam logic [`ASMC_CNT_W-1:0] READ_CYC =
        `ASMC_CNT_W'(`ASMC_READ_CYC);
    localparam logic [`ASMC_CNT_W-1:0] HIZ_CYC =
        `ASMC_CNT_W'(`ASMC_HIZ_CYC);
    localparam logic [`ASMC_CNT_W-1:0] WPULSE_CYC =
        `ASMC_CNT_W'(`ASMC_WPULSE_CYC);
    localparam logic [`ASMC_CNT_W-1:0] OEOFF_CYC =
        `ASMC_CNT_W'(`ASMC_OEOFF_CYC);
    localparam logic [`ASMC_CNT_W-1:0] RECOV_CYC =
        `ASMC_CNT_W'(`ASMC_RECOV_CYC);

    asmc_pkg::asmc_state_t    state_reg;
    asmc_pkg::asmc_state_t    state_next;
    logic [`ASMC_CNT_W-1:0]   cnt_reg;
    logic [`ASMC_CNT_W-1:0]   cnt_next;
    logic                     ready_reg;
    logic                     ready_next;
    logic                     rvalid_reg;
    logic                     rvalid_next;
    logic [`ASMC_DATA_W-1:0]  rdata_reg;
    logic [`ASMC_DATA_W-1:0]  rdata_next;
    logic [`ASMC_ADDR_W-1:0]  addr_reg;
    logic [`ASMC_ADDR_W-1:0]  addr_next;
    logic [`ASMC_DATA_W-1:0]  wdata_reg;
    logic [`ASMC_DATA_W-1:0]  wdata_next;
    logic                     ce_reg;
    logic                     ce_next;
    logic                     oe_reg;
    logic                     oe_next;
    logic                     we_reg;
    logic                     we_next;
    logic                     doe_reg;
    logic                     doe_next;
    logic [`ASMC_DATA_W-1:0]  data_sync;

    // data pins are asynchronous: two flops before any use
    asmc_sync u_sync (
        .clock (clock),
        .rstn  (rstn),
        .din   (data_in),
        .dout  (data_sync)
    );

    always_comb begin
        state_next  = state_reg;
        cnt_next    = cnt_reg;
        ready_next  = ready_reg;
        rvalid_next = 1'b0;
        rdata_next  = rdata_reg;
        addr_next   = addr_reg;
        wdata_next  = wdata_reg;
        ce_next     = ce_reg;
        oe_next     = oe_reg;
        we_next     = we_reg;
        doe_next    = doe_reg;
        case (state_reg)
            asmc_pkg::ASMC_IDLE: begin
                if (req_valid && ready_reg) begin
                    ready_next = 1'b0;
                    addr_next  = req_addr; // see (R1)
                    wdata_next = req_wdata;
                    ce_next    = 1'b0; // see (R6)
                    if (req_write) begin
                        // output enable off first so data can float
                        oe_next    = 1'b1;
                        we_next    = 1'b0; // see (R3)
                        cnt_next   = HIZ_CYC;
                        state_next = asmc_pkg::ASMC_WR_HIZ;
                    end else begin
                        // address, select and output together
                        oe_next    = 1'b0; // see (R4)
                        we_next    = 1'b1;
                        cnt_next   = READ_CYC; // see (R7)
                        state_next = asmc_pkg::ASMC_RD_ACCESS;
                    end
                end
            end
            asmc_pkg::ASMC_RD_ACCESS: begin
                // address held steady for whole access, see (R11)
                if (cnt_reg == 1) begin
                    // data sampled after sync delay past 100 ns, see (R8)
                    rdata_next  = data_sync; // see (R12)
                    rvalid_next = 1'b1;
                    oe_next     = 1'b1;
                    ce_next     = 1'b1; // see (R2)
                    cnt_next    = OEOFF_CYC;
                    state_next  = asmc_pkg::ASMC_RD_OFF;
                end else begin
                    cnt_next = cnt_reg - 1'b1;
                end
            end
            asmc_pkg::ASMC_RD_OFF: begin
                // memory drivers float before anything else may drive
                if (cnt_reg == 1) begin
                    cnt_next   = RECOV_CYC;
                    state_next = asmc_pkg::ASMC_RECOVER;
                end else begin
                    cnt_next = cnt_reg - 1'b1;
                end
            end
            asmc_pkg::ASMC_WR_HIZ: begin
                // data waits until the memory has floated its outputs
                if (cnt_reg == 1) begin
                    doe_next   = 1'b0; // see (R14)
                    cnt_next   = WPULSE_CYC;
                    state_next = asmc_pkg::ASMC_WR_PULSE;
                end else begin
                    cnt_next = cnt_reg - 1'b1;
                end
            end
            asmc_pkg::ASMC_WR_PULSE: begin
                // strobe and select fell together; width from then
                if (cnt_reg == 1) begin
                    we_next    = 1'b1; // see (R13)
                    ce_next    = 1'b1; // see (R15)
                    cnt_next   = RECOV_CYC;
                    state_next = asmc_pkg::ASMC_RECOVER;
                end else begin
                    cnt_next = cnt_reg - 1'b1;
                end
            end
            asmc_pkg::ASMC_RECOVER: begin
                // data held one extra cycle past ending edge, see (R16)
                doe_next = 1'b1;
                if (cnt_reg == 1) begin
                    ready_next = 1'b1; // see (R10)
                    state_next = asmc_pkg::ASMC_IDLE;
                end else begin
                    cnt_next = cnt_reg - 1'b1;
                end
            end
            default: begin
                state_next = asmc_pkg::ASMC_IDLE;
                ready_next = 1'b1;
                ce_next    = 1'b1;
                oe_next    = 1'b1;
                we_next    = 1'b1;
                doe_next   = 1'b1;
            end
        endcase
    end

    // reset leaves the memory deselected, in standby
    always_ff @(posedge clock) begin
        if (!rstn) begin
            state_reg  <= asmc_pkg::ASMC_IDLE;
            cnt_reg    <= '0;
            ready_reg  <= 1'b1;
            rvalid_reg <= 1'b0;
            rdata_reg  <= '0;
            addr_reg   <= '0;
            wdata_reg  <= '0;
            ce_reg     <= 1'b1;
            oe_reg     <= 1'b1;
            we_reg     <= 1'b1;
            doe_reg    <= 1'b1;
        end else begin
            state_reg  <= state_next;
            cnt_reg    <= cnt_next;
            ready_reg  <= ready_next;
            rvalid_reg <= rvalid_next;
            rdata_reg  <= rdata_next;
            addr_reg   <= addr_next;
            wdata_reg  <= wdata_next;
            ce_reg     <= ce_next;
            oe_reg     <= oe_next;
            we_reg     <= we_next;
            doe_reg    <= doe_next;
        end
    end

    // every output comes straight from a flip-flop
    assign req_ready    = ready_reg;
    assign rsp_valid    = rvalid_reg;
    assign rsp_rdata    = rdata_reg;
    assign mem_addr     = addr_reg;
    assign chip_on_n    = ce_reg;
    assign output_on_n  = oe_reg;
    assign stor_strob_n = we_reg;
    assign data_out     = wdata_reg;
    assign data_oe_n    = doe_reg;
endmodule : asmc_host

//--- test/asmc_mem_model.sv
// Purpose: behavioural async static memory facing the host
// Assumes: times in ns; the bench resolves the data wire
// Notes:   shows a changing pattern while it is not driving
`timescale 1ns/100ps
`include "asmc_cfg.svh"
module asmc_mem_model (
    input  wire logic [`ASMC_ADDR_W-1:0] addr,
    input  wire logic                    chip_on_n,
    input  wire logic                    output_on_n,
    input  wire logic                    stor_strob_n,
    input  wire logic [`ASMC_DATA_W-1:0] data_wire,
    output logic      [`ASMC_DATA_W-1:0] q,
    output logic                         q_on
);
    logic [`ASMC_DATA_W-1:0] mem [int];
    logic                    wr_act = 1'b0;
    realtime                 t_ev = 0;
    initial q = 8'h5A;
    // standby when deselected, drives only in the read mode
    assign q_on = !chip_on_n && !output_on_n
                  && stor_strob_n;
    always @(addr or chip_on_n or output_on_n) begin
        t_ev = $realtime;
    end
    always @(chip_on_n or stor_strob_n) begin
        if (wr_act && (chip_on_n || stor_strob_n)) begin
            mem[addr] = data_wire;
        end
        wr_act = !chip_on_n && !stor_strob_n;
    end
    always #5 begin
        if (q_on && ($realtime - t_ev >= `ASMC_ADDRESS_ACCESS_NS)
                && mem.exists(addr)) begin
            q = mem[addr];
        end else begin
            q = ~q;
        end
    end
endmodule : asmc_mem_model

//--- test/asmc_host_props.sv
// Purpose: pin timing checks for the static memory host
// Assumes: one clock, synchronous active low reset
// Notes:   counts follow the cycle constants of the timing header
`timescale 1ns/100ps
`include "asmc_cfg.svh"
module asmc_host_props (
    input wire logic                    clock,
    input wire logic                    rstn,
    input wire logic                    req_valid,
    input wire logic                    req_write,
    input wire logic                    req_ready,
    input wire logic                    rsp_valid,
    input wire logic [`ASMC_ADDR_W-1:0] mem_addr,
    input wire logic                    chip_on_n,
    input wire logic                    output_on_n,
    input wire logic                    stor_strob_n,
    input wire logic [`ASMC_DATA_W-1:0] data_out,
    input wire logic                    data_oe_n
);
    // answer is sampled one edge after the register that raises it
    localparam int RSP_DLY = `ASMC_READ_CYC + 1;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    sequence s_take_rd; req_valid && req_ready && !req_write; endsequence
    sequence s_take_wr; req_valid && req_ready && req_write; endsequence
    sequence s_rd_pins; !chip_on_n && !output_on_n && stor_strob_n; endsequence
    property p_rd_start; s_take_rd |=> s_rd_pins ##0 data_oe_n; endproperty
    property p_wr_start;
        s_take_wr |=> !chip_on_n && !stor_strob_n && output_on_n && !req_ready;
    endproperty
    property p_rd_resp;
        s_take_rd |-> ##[RSP_DLY:RSP_DLY] rsp_valid ##1 !rsp_valid;
    endproperty
    property p_hiz;
        $fell(stor_strob_n) |-> data_oe_n[*2] ##1 !data_oe_n;
    endproperty
    property p_width;
        $fell(stor_strob_n) |-> !stor_strob_n[*6] ##1 stor_strob_n;
    endproperty
    property p_oe_off; !data_oe_n |-> output_on_n; endproperty
    property p_addr_hold;
        !chip_on_n && !$past(chip_on_n) |-> $stable(mem_addr);
    endproperty
    property p_data_hold;
        !data_oe_n && !$past(data_oe_n) |-> $stable(data_out);
    endproperty
    property p_wr_end; $rose(stor_strob_n) |-> $rose(chip_on_n); endproperty
    property p_recover; $rose(chip_on_n) |-> chip_on_n[*5]; endproperty
    a_rd_start: assert property (p_rd_start)
        else $error("read pins");
    a_wr_start: assert property (p_wr_start)
        else $error("write pins");
    a_rd_resp: assert property (p_rd_resp)
        else $error("no read data");
    a_hiz: assert property (p_hiz)
        else $error("early data drive");
    a_width: assert property (p_width)
        else $error("strobe width");
    a_oe_off: assert property (p_oe_off)
        else $error("output on");
    a_addr_hold: assert property (p_addr_hold)
        else $error("addr moved");
    a_data_hold: assert property (p_data_hold)
        else $error("data moved");
    a_wr_end: assert property (p_wr_end)
        else $error("write end");
    a_recover: assert property (p_recover)
        else $error("recovery");
endmodule : asmc_host_props
bind asmc_host asmc_host_props u_props (.clock(clock), .rstn(rstn),
    .req_valid(req_valid), .req_write(req_write), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .mem_addr(mem_addr), .chip_on_n(chip_on_n),
    .output_on_n(output_on_n), .stor_strob_n(stor_strob_n),
    .data_out(data_out), .data_oe_n(data_oe_n));

//--- test/asmc_host_tb.sv
// Purpose: self-checking bench for the static memory host
// Assumes: 50 MHz clock, inputs change at the falling edge
// Notes:   expected bytes come from a reference array
`timescale 1ns/100ps
`include "asmc_cfg.svh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
    $display("wrong value %s exp %h got %h", n, e, g); err_count++; end end
module asmc_host_tb;
    logic                    clock, rstn, req_valid, req_write;
    logic [`ASMC_ADDR_W-1:0] req_addr, mem_addr;
    logic [`ASMC_DATA_W-1:0] req_wdata, rsp_rdata, data_in, data_out, q;
    logic                    req_ready, rsp_valid, chip_on_n, output_on_n;
    logic                    stor_strob_n, data_oe_n, q_on;
    logic [`ASMC_DATA_W-1:0] ref_mem [int];
    logic [`ASMC_ADDR_W-1:0] a_q [12];
    logic [31:0]             seed = 32'hE16DCFB0;
    int                      err_count = 0, compares = 0;
    logic [5:0]              idle_pins;
    assign data_in = !data_oe_n ? data_out : q;
    assign idle_pins = {req_ready, chip_on_n, output_on_n, stor_strob_n,
                        rsp_valid, data_oe_n};
    asmc_host dut (.clock(clock), .rstn(rstn), .req_valid(req_valid),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .mem_addr(mem_addr), .chip_on_n(chip_on_n), .output_on_n(output_on_n),
        .stor_strob_n(stor_strob_n), .data_in(data_in), .data_out(data_out),
        .data_oe_n(data_oe_n));
    asmc_mem_model u_mem (.addr(mem_addr), .chip_on_n(chip_on_n),
        .output_on_n(output_on_n), .stor_strob_n(stor_strob_n),
        .data_wire(data_in), .q(q), .q_on(q_on));
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    task end_of_test;
        if (err_count == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_of_test
    task automatic req(input logic is_wr, input logic [`ASMC_ADDR_W-1:0] a,
                       input logic [`ASMC_DATA_W-1:0] d);
        int n;
        n = 0;
        @(negedge clock);
        // ready is registered: high here means taken at the next edge
        while (req_ready !== 1'b1 && n < 50) begin
            @(negedge clock);
            n++;
        end
        if (n >= 50) err_count++;
        req_valid = 1'b1;
        req_write = is_wr;
        req_addr  = a;
        req_wdata = d;
        @(negedge clock);
        req_valid = 1'b0;
        req_addr  = ~a;
        req_wdata = ~d;
    endtask : req
    task automatic wr(input logic [18:0] a, input logic [7:0] d);
        ref_mem[a] = d;
        req(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [18:0] a);
        int n;
        n = 0;
        req(1'b0, a, 8'h00);
        while (rsp_valid !== 1'b1 && n < 20) begin
            @(negedge clock);
            n++;
        end
        `CHK("read latency", `ASMC_READ_CYC, n)
        `CHK("rdata", ref_mem[a], rsp_rdata)
        @(negedge clock);
        `CHK("rsp_valid", 1'b0, rsp_valid)
        `CHK("chip_on_n", 1'b1, chip_on_n)
    endtask : rd
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    // host and memory must never drive the wire at once
    always @(negedge clock) begin
        if (rstn) `CHK("contention", 1'b0, q_on & ~data_oe_n)
    end
    initial begin
        #100000;
        err_count++;
        end_of_test();
    end
    initial begin
        rstn = 1'b0;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_addr = '0;
        req_wdata = '0;
        repeat (8) @(negedge clock);
        rstn = 1'b1;
        // corner addresses first, odd steps read straight back
        for (int i = 0; i < 12; i++) begin
            seed = lfsr(seed);
            a_q[i] = (i == 0) ? 19'h00000 : (i == 1) ? 19'h7FFFF : seed[18:0];
            wr(a_q[i], seed[26:19]);
            if (i % 2 == 1) rd(a_q[i]);
        end
        // reset in mid-read: every pin returns to idle, no answer
        req(1'b0, a_q[3], 8'h00);
        repeat (3) @(negedge clock);
        rstn = 1'b0;
        repeat (2) @(negedge clock);
        rstn = 1'b1;
        `CHK("idle pins", 6'h3D, idle_pins)
        wr(a_q[2], 8'h3C);
        for (int i = 0; i < 12; i++) rd(a_q[i]);
        end_of_test();
    end
endmodule : asmc_host_tb
